// [design/debug_wire_pkg.sv]
// Shared bit-timing constants for the single-wire debug link
package debug_wire_pkg;

    // =====================================================================
    // Cycle counter
    // =====================================================================
    localparam int CNT_W = 5;

    // =====================================================================
    // Target timing, in target clock cycles from the recognised bit start
    // =====================================================================
    localparam logic [4:0] TGT_GLITCH_AT = 5'h08;   // Wire must be high by now for a one
    localparam logic [4:0] TGT_SAMPLE_AT = 5'h0a;   // Host-to-target sampling point
    localparam logic [4:0] TGT_SPEEDUP_AT = 5'h07;  // First cycle of the speedup pulse
    localparam logic [4:0] TGT_SPEEDUP_LEN = 5'h02;
    localparam logic [4:0] TGT_ZERO_END = 5'h0d;    // Target low drive for a zero ends here
    localparam logic [4:0] TGT_BIT_END = 5'h0e;     // Last counted cycle of a bit

    // =====================================================================
    // Host timing, in cycles from the host's own falling edge
    // =====================================================================
    localparam logic [4:0] HOST_ONE_LOW = 5'h04;    // Low time for a one, well under 8
    localparam logic [4:0] HOST_ZERO_LOW = 5'h0d;   // Low time for a zero, past sampling
    localparam logic [4:0] HOST_RX_LOW = 5'h03;     // Low time to start a receive bit
    localparam logic [4:0] HOST_PULSE_LEN = 5'h02;  // Driven high speedup pulse
    localparam logic [4:0] HOST_SAMPLE_AT = 5'h0a;  // Host reads returned level here
    localparam logic [4:0] HOST_BIT_END = 5'h0f;    // Last cycle of a host bit slot

    // =====================================================================
    // Buffering and word size
    // =====================================================================
    localparam int WORD_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam logic [3:0] WORD_BITS_LEFT = 4'h7;   // Bits still to send after the first

    // Counter lies inside [lo, lo+len)
    function automatic logic in_window(input logic [4:0] cnt, input logic [4:0] lo,
                                       input logic [4:0] len);
        in_window = (cnt >= lo) && (cnt < 5'(lo + len));
    endfunction

endpackage

// [design/debug_wire_if.sv]
// Single-wire debug link carrier with one modport per party
`timescale 1ns/1ps
interface debug_wire_if;
    logic host_out;
    logic host_oe_b;
    logic tgt_out;
    logic tgt_oe_b;
    logic level;

    // Wired pin with pull-up: any low drive wins, otherwise driven or pulled high
    assign level = ~((~host_oe_b & ~host_out) | (~tgt_oe_b & ~tgt_out));

    modport host (
        output host_out,
        output host_oe_b,
        input level
    );
    modport target (
        output tgt_out,
        output tgt_oe_b,
        input level
    );
endinterface

// [design/debug_target_end.sv]
// Target end of the debug wire: bit timing, send FIFO and byte framing
//
// Overview of operation
// - Every bit starts at host falling edge.
// - Target recognises the edge within one cycle.
// - Target samples host bits ten cycles later.
// - Host returns high within eight for one.
// - Host actively drives its speedup pulse.
// - Host holds low three cycles to start.
// - Target drives one speedup at seven cycles.
// - Host releases low before target speedup.
// - Host samples returned bit near ten cycles.
`timescale 1ns/1ps

// =========================================================================
// Send buffer
// =========================================================================
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W + 1)'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_IDX = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_idx;
    logic [PTR_W-1:0] rd_idx;
    logic [PTR_W:0] fill;
    logic [PTR_W-1:0] next_wr_idx;
    logic [PTR_W-1:0] next_rd_idx;
    logic [PTR_W:0] next_fill;
    logic push;
    logic pop;

    // Honest flags straight from the fill count
    assign in_ready = (fill != DEPTH_CNT);
    assign out_valid = (fill != '0);
    assign out_data = mem[rd_idx];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and fill bookkeeping
    always_comb begin
        next_wr_idx = wr_idx;
        next_rd_idx = rd_idx;
        next_fill = fill;
        if (push) begin
            next_wr_idx = (wr_idx == LAST_IDX) ? '0 : PTR_W'(wr_idx + 1'b1);
        end
        if (pop) begin
            next_rd_idx = (rd_idx == LAST_IDX) ? '0 : PTR_W'(rd_idx + 1'b1);
        end
        if (push && !pop) begin
            next_fill = (PTR_W + 1)'(fill + 1'b1);
        end else if (pop && !push) begin
            next_fill = (PTR_W + 1)'(fill - 1'b1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_idx <= '0;
            rd_idx <= '0;
            fill <= '0;
        end else begin
            wr_idx <= next_wr_idx;
            rd_idx <= next_rd_idx;
            fill <= next_fill;
        end
    end

    // Storage has no reset; contents are only read while counted valid
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_idx] <= in_data;
        end
    end
endmodule

// =========================================================================
// Target end
// =========================================================================
module debug_target_end (
    input wire logic sys_clk,
    input wire logic rst_b,
    debug_wire_if.target link,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_glitch,
    output logic bit_busy
);
    typedef enum logic [1:0] {
        TGT_IDLE = 2'b00,
        TGT_RECV = 2'b01,
        TGT_SEND = 2'b10
    } tgt_state_t;

    tgt_state_t state;
    tgt_state_t next_state;
    logic [4:0] count;
    logic [4:0] next_count;
    logic prev_level;
    logic send_bit;
    logic next_send_bit;
    logic [7:0] tx_shift;
    logic [7:0] next_tx_shift;
    logic [3:0] tx_left;
    logic [3:0] next_tx_left;
    logic [7:0] rx_shift;
    logic [7:0] next_rx_shift;
    logic [2:0] rx_cnt;
    logic [2:0] next_rx_cnt;
    logic late_low;
    logic next_late_low;
    logic next_rx_valid;
    logic [7:0] next_rx_data;
    logic next_rx_glitch;
    logic fall;
    logic fifo_valid;
    logic fifo_pop;
    logic [7:0] fifo_data;
    logic drive_low;
    logic drive_high;

    // Four-word buffer between user and serializer; fills while host is slow
    word_fifo #(
        .WIDTH(debug_wire_pkg::WORD_W),
        .DEPTH(debug_wire_pkg::FIFO_DEPTH)
    ) send_fifo (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // Wire is synchronous to sys_clk, so the edge shows in the same cycle
    assign fall = prev_level && !link.level;
    assign fifo_pop = (state == TGT_IDLE) && fall && (tx_left == 4'h0) && fifo_valid;

    // Bit sequencer: every bit re-synchronises on a fresh falling edge
    always_comb begin
        next_state = state;
        next_count = count;
        next_send_bit = send_bit;
        next_tx_shift = tx_shift;
        next_tx_left = tx_left;
        next_rx_shift = rx_shift;
        next_rx_cnt = rx_cnt;
        next_late_low = late_low;
        next_rx_valid = 1'b0;
        next_rx_data = rx_data;
        next_rx_glitch = 1'b0;
        case (state)
            TGT_IDLE: begin
                next_count = 5'h01;
                next_late_low = 1'b0;
                if (fall) begin
                    if (tx_left != 4'h0) begin
                        next_state = TGT_SEND;
                        next_send_bit = tx_shift[7];
                        next_tx_shift = {tx_shift[6:0], 1'b0};
                        next_tx_left = 4'(tx_left - 1'b1);
                    end else if (fifo_valid) begin
                        next_state = TGT_SEND;
                        next_send_bit = fifo_data[7];
                        next_tx_shift = {fifo_data[6:0], 1'b0};
                        next_tx_left = debug_wire_pkg::WORD_BITS_LEFT;
                    end else begin
                        next_state = TGT_RECV;
                    end
                end
            end
            TGT_RECV: begin
                next_count = 5'(count + 1'b1);
                // Still low here means a one came back too late
                if (count == debug_wire_pkg::TGT_GLITCH_AT) begin
                    next_late_low = !link.level;
                end
                if (count == debug_wire_pkg::TGT_SAMPLE_AT) begin
                    if (late_low && link.level) begin
                        next_rx_glitch = 1'b1;
                    end else begin
                        next_rx_shift = {rx_shift[6:0], link.level};
                        next_rx_cnt = 3'(rx_cnt + 1'b1);
                        if (rx_cnt == 3'h7) begin
                            next_rx_valid = 1'b1;
                            next_rx_data = {rx_shift[6:0], link.level};
                        end
                    end
                end
                if (count == debug_wire_pkg::TGT_BIT_END) begin
                    next_state = TGT_IDLE;
                end
            end
            TGT_SEND: begin
                next_count = 5'(count + 1'b1);
                if (count == debug_wire_pkg::TGT_BIT_END) begin
                    next_state = TGT_IDLE;
                end
            end
            default: begin
                next_state = TGT_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= TGT_IDLE;
            count <= 5'h00;
            prev_level <= 1'b1;
            send_bit <= 1'b0;
            tx_shift <= 8'h00;
            tx_left <= 4'h0;
            rx_shift <= 8'h00;
            rx_cnt <= 3'h0;
            late_low <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            rx_glitch <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            prev_level <= link.level;
            send_bit <= next_send_bit;
            tx_shift <= next_tx_shift;
            tx_left <= next_tx_left;
            rx_shift <= next_rx_shift;
            rx_cnt <= next_rx_cnt;
            late_low <= next_late_low;
            rx_valid <= next_rx_valid;
            rx_data <= next_rx_data;
            rx_glitch <= next_rx_glitch;
        end
    end

    // Pin drive from registered state only, so the wire never glitches
    // A zero is held low past the host's sampling point; a one is a brief
    // driven high pulse, relying on the host having let go by then
    assign drive_low = (state == TGT_SEND) && !send_bit && (count < debug_wire_pkg::TGT_ZERO_END);
    assign drive_high = (state == TGT_SEND) && send_bit &&
        debug_wire_pkg::in_window(count, debug_wire_pkg::TGT_SPEEDUP_AT,
                                  debug_wire_pkg::TGT_SPEEDUP_LEN);
    assign link.tgt_out = drive_high;
    assign link.tgt_oe_b = !(drive_low || drive_high);
    assign bit_busy = (state != TGT_IDLE);
endmodule

// [design/debug_host_end.sv]
// Host end of the debug wire: one bit per request, either direction
`timescale 1ns/1ps
module debug_host_end (
    input wire logic sys_clk,
    input wire logic rst_b,
    debug_wire_if.host link,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_receive,
    input wire logic req_bit,
    output logic rsp_valid,
    output logic rsp_bit
);
    typedef enum logic {
        HOST_IDLE = 1'b0,
        HOST_BUSY = 1'b1
    } host_state_t;

    // =====================================================================
    // Bit slot sequencer
    // =====================================================================
    host_state_t state;
    host_state_t next_state;
    logic [4:0] count;
    logic [4:0] next_count;
    logic receive;
    logic next_receive;
    logic send_bit;
    logic next_send_bit;
    logic next_rsp_valid;
    logic next_rsp_bit;
    logic [4:0] low_len;
    logic drive_low;
    logic drive_high;

    assign req_ready = (state == HOST_IDLE);

    // One request opens a fixed-length slot that starts with a falling edge
    always_comb begin
        next_state = state;
        next_count = count;
        next_receive = receive;
        next_send_bit = send_bit;
        next_rsp_valid = 1'b0;
        next_rsp_bit = rsp_bit;
        case (state)
            HOST_IDLE: begin
                next_count = 5'h00;
                if (req_valid) begin
                    next_state = HOST_BUSY;
                    next_receive = req_receive;
                    next_send_bit = req_bit;
                end
            end
            HOST_BUSY: begin
                next_count = 5'(count + 1'b1);
                if (receive && count == debug_wire_pkg::HOST_SAMPLE_AT) begin
                    next_rsp_bit = link.level;
                end
                if (count == debug_wire_pkg::HOST_BIT_END) begin
                    next_state = HOST_IDLE;
                    next_rsp_valid = 1'b1;
                end
            end
            default: begin
                next_state = HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= HOST_IDLE;
            count <= 5'h00;
            receive <= 1'b0;
            send_bit <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_bit <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            receive <= next_receive;
            send_bit <= next_send_bit;
            rsp_valid <= next_rsp_valid;
            rsp_bit <= next_rsp_bit;
        end
    end

    // =====================================================================
    // Pin drive
    // =====================================================================
    // Low time per bit kind; receive low is short so it is gone before
    // the target's speedup pulse, yet long enough to be recognised
    always_comb begin
        if (receive) begin
            low_len = debug_wire_pkg::HOST_RX_LOW;
        end else if (send_bit) begin
            low_len = debug_wire_pkg::HOST_ONE_LOW;
        end else begin
            low_len = debug_wire_pkg::HOST_ZERO_LOW;
        end
    end

    // Host sends end with an actively driven high pulse, not the pull-up
    assign drive_low = (state == HOST_BUSY) && (count < low_len);
    assign drive_high = (state == HOST_BUSY) && !receive &&
        debug_wire_pkg::in_window(count, low_len, debug_wire_pkg::HOST_PULSE_LEN);
    assign link.host_out = drive_high;
    assign link.host_oe_b = !(drive_low || drive_high);
endmodule

// [test/debug_wire_chk.sv]
// Wire-level checker for the single-wire debug link between host and target
`timescale 1ns/1ps
module debug_wire_chk (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic host_out,
    input wire logic host_oe_b,
    input wire logic tgt_out,
    input wire logic tgt_oe_b,
    input wire logic level
);
    // =====================================================================
    // Cycles since the last falling edge on the wire
    // =====================================================================
    logic prev_level;
    logic next_prev_level;
    logic fall;
    logic [4:0] since;
    logic [4:0] next_since;

    // Saturates so a long idle gap never wraps into a false slot position
    always_comb begin
        next_prev_level = level;
        fall = prev_level & ~level;
        if (fall) begin
            next_since = 5'h01;
        end else if (since != 5'h1f) begin
            next_since = since + 5'h01;
        end else begin
            next_since = since;
        end
    end

    // Idle wire is high, so reset the history high to avoid a false start
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_level <= 1'b1;
            since <= 5'h1f;
        end else begin
            prev_level <= next_prev_level;
            since <= next_since;
        end
    end

    // =====================================================================
    // Wire properties
    // =====================================================================
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence host_low_s; !host_oe_b && !host_out; endsequence
    sequence host_high_s; !host_oe_b && host_out; endsequence
    sequence tgt_pulse_s; !tgt_oe_b && tgt_out; endsequence

    host_start_a: assert property (fall |-> !host_oe_b && !host_out)
        else $error("bit start not driven by host");
    slot_gap_a: assert property (fall |-> since >= 5'h10)
        else $error("bit start inside previous slot");
    tgt_window_a: assert property (!tgt_oe_b |-> since <= 5'h0e)
        else $error("target drives outside a slot");
    tgt_start_a: assert property ($fell(tgt_oe_b) |->
        (since <= 5'h02 && !tgt_out) || (since >= 5'h07 && since <= 5'h09 && tgt_out))
        else $error("target drive starts off time");
    tgt_pulse_a: assert property ($rose(tgt_out && !tgt_oe_b) |->
        (since >= 5'h07 && since <= 5'h09) ##1 tgt_pulse_s ##1 tgt_oe_b)
        else $error("target speedup pulse wrong");
    host_release_a: assert property (tgt_pulse_s |-> host_oe_b)
        else $error("host still drives during target pulse");
    no_fight_a: assert property (!host_oe_b && !tgt_oe_b |-> host_out == tgt_out)
        else $error("host and target drive opposite levels");
    host_pulse_a: assert property (host_low_s ##1 host_high_s |=> host_high_s ##1 host_oe_b)
        else $error("host speedup pulse wrong");
    host_low_a: assert property (host_low_s ##1 host_high_s |-> since == 5'h04 || since == 5'h0d)
        else $error("host low time wrong");
    rx_start_a: assert property (host_low_s ##1 host_oe_b |-> since == 5'h03)
        else $error("receive start low time wrong");
endmodule

// [test/tb_debug_single_wire_bit_timing.sv]
// Self-checking bench for the single-wire debug link with both ends joined
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("MISMATCH %s expected %h seen %h", what, exp, got); \
        end \
    end

module tb_debug_single_wire_bit_timing;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic req_receive = 1'b0;
    logic req_bit = 1'b0;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic req_ready, rsp_valid, rsp_bit, tx_ready, rx_valid, rx_glitch, rx2_valid, rx2_glitch;
    logic [7:0] rx_data, rx2_data;
    logic bit_busy;
    logic [7:0] rx_last = 8'h00;
    logic [7:0] rx2_last = 8'h00;
    int mismatches = 0;
    int check_count = 0;
    int cycle_count = 0;
    int rx_count = 0;
    int rx2_count = 0;
    int glitch_count = 0;
    int glitch1_count = 0;

    always #4 sys_clk = ~sys_clk;

    // =====================================================================
    // Links and ends; the second link is driven by hand to break rules
    // =====================================================================
    debug_wire_if debug_wire_if_inst ();
    debug_wire_if fault_link ();

    debug_host_end debug_host_end_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .link(debug_wire_if_inst), .req_valid(req_valid), .req_ready(req_ready),
        .req_receive(req_receive), .req_bit(req_bit), .rsp_valid(rsp_valid), .rsp_bit(rsp_bit));
    debug_target_end debug_target_end_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .link(debug_wire_if_inst), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_glitch(rx_glitch), .bit_busy(bit_busy));
    debug_target_end debug_target_end_inst_b (.sys_clk(sys_clk), .rst_b(rst_b),
        .link(fault_link), .tx_valid(1'b0), .tx_ready(), .tx_data(8'h00),
        .rx_valid(rx2_valid), .rx_data(rx2_data), .rx_glitch(rx2_glitch), .bit_busy());
    debug_wire_chk debug_wire_chk_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .host_out(debug_wire_if_inst.host_out), .host_oe_b(debug_wire_if_inst.host_oe_b),
        .tgt_out(debug_wire_if_inst.tgt_out), .tgt_oe_b(debug_wire_if_inst.tgt_oe_b),
        .level(debug_wire_if_inst.level));

    // Tally words and rejected bits; pulses last one cycle only
    always @(posedge sys_clk) begin
        if (rx_valid === 1'b1) begin
            rx_count++;
            rx_last = rx_data;
        end
        if (rx2_valid === 1'b1) begin
            rx2_count++;
            rx2_last = rx2_data;
        end
        glitch1_count += int'(rx_glitch === 1'b1);
        glitch_count += int'(rx2_glitch === 1'b1);
    end

    // Hang guard, well above the roughly 1500 cycles the tests need
    always @(posedge sys_clk) begin
        cycle_count++;
        if (cycle_count == 6000) begin
            mismatches++;
            complete_run();
        end
    end

    // =====================================================================
    // Tasks
    // =====================================================================
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One host slot; request held until the edge that takes it
    task automatic host_bit(input logic rcv, input logic b, output logic got);
        int n;
        @(posedge sys_clk);
        #1;
        req_valid = 1'b1;
        req_receive = rcv;
        req_bit = b;
        n = 0;
        while (req_ready !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n == 8) begin
                `CHK("slot busy", 1'b1, bit_busy)
            end
        end
        // A missing answer ends the loop at its limit and shows up here
        `CHK("slot length", int'(debug_wire_pkg::HOST_BIT_END) + 1, n)
        got = rsp_bit;
    endtask

    // Hand-made host bit on the second link: low, driven high pulse, release
    task automatic fault_bit(input int low_len);
        @(posedge sys_clk);
        #1;
        fault_link.host_oe_b = 1'b0;
        fault_link.host_out = 1'b0;
        repeat (low_len) @(posedge sys_clk);
        #1;
        fault_link.host_out = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        fault_link.host_oe_b = 1'b1;
        repeat (16) @(posedge sys_clk);
    endtask

    // Boundary words all zero and all one, then a mixed one
    task automatic test_host_to_target();
        logic [7:0] pat [3] = '{8'h00, 8'hff, 8'ha5};
        logic got;
        int start;
        for (int k = 0; k < 3; k++) begin
            start = rx_count;
            for (int i = 7; i >= 0; i--) begin
                host_bit(1'b0, pat[k][i], got);
            end
            `CHK("host word count", 1, rx_count - start)
            `CHK("host word", pat[k], rx_last)
            `CHK("target idle", 1'b0, bit_busy)
        end
        `CHK("target rejects", 0, glitch1_count)
        $display("test host_to_target done");
    endtask

    // Fill the buffer until it refuses, then drain it with receive slots
    task automatic test_target_to_host();
        logic [7:0] words [5] = '{8'h81, 8'h7e, 8'h00, 8'hff, 8'h5a};
        logic [7:0] got_word;
        logic got;
        tx_valid = 1'b1;
        for (int k = 0; k < 4; k++) begin
            tx_data = words[k];
            `CHK("buffer space", 1'b1, tx_ready)
            @(posedge sys_clk);
            #1;
        end
        tx_valid = 1'b0;
        `CHK("buffer full", 1'b0, tx_ready)
        for (int k = 0; k < 40; k++) begin
            host_bit(1'b1, 1'b0, got);
            got_word = {got_word[6:0], got};
            if (k == 0) begin
                `CHK("buffer freed", 1'b1, tx_ready)
                tx_valid = 1'b1;
                tx_data = words[4];
                @(posedge sys_clk);
                #1;
                tx_valid = 1'b0;
            end
            if (k % 8 == 7) begin
                `CHK("target word", words[k / 8], got_word)
            end
        end
        $display("test target_to_host done");
    endtask

    // Boundary low times: nine is rejected, eight is a one, eleven a zero
    task automatic test_fault_link();
        logic [7:0] pat = 8'hc3;
        fault_bit(9);
        for (int i = 7; i >= 0; i--) begin
            fault_bit(pat[i] ? 8 : 11);
        end
        `CHK("rejected bits", 1, glitch_count)
        `CHK("fault word count", 1, rx2_count)
        `CHK("fault word", pat, rx2_last)
        $display("test fault_link done");
    endtask

    initial begin
        fault_link.host_oe_b = 1'b1;
        fault_link.host_out = 1'b1;
        repeat (16) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        `CHK("idle host", 1'b1, req_ready)
        `CHK("idle buffer", 1'b1, tx_ready)
        test_host_to_target();
        test_target_to_host();
        test_fault_link();
        complete_run();
    end
endmodule
